// File: ecp_bridge_model.sv
// Bridge switches with pull-downs, plus the fault and comparator sources.
`timescale 1ns/100ps
module ecp_bridge_model (
  // Pins from the unit
  input wire logic [3:0] pin_i,
  input wire logic [3:0] oe_n_i,
  // Commands from the bench
  input wire logic [2:0] trip_i,
  input wire logic ext_a_i,
  // Lines back to the unit
  output logic [3:0] wire_o,
  output logic fault_n_o,
  output logic cmp1_o,
  output logic cmp2_o
);
  // Released pins fall to the pull-down so the switches stay off; pin A then carries the
  // external capture signal instead.
  assign wire_o = (~oe_n_i & pin_i) | (oe_n_i & {3'h0, ext_a_i});
  assign fault_n_o = ~trip_i[0];
  assign cmp1_o = trip_i[1];
  assign cmp2_o = trip_i[2];
endmodule // ecp_bridge_model

// File: ecp_deadband.sv
// Delay of the active-going edge of one output by a count of quarter-clock ticks.
`timescale 1ns/100ps
`include "ecp_regs.svh"
module ecp_deadband (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Quarter-clock tick and delay
  input wire logic tick_i,
  input wire logic [6:0] delay_i,
  // Level in and delayed level out
  input wire logic level_i,
  output logic level_o
);
  logic [6:0] count_reg;
  logic out_reg;

  // The falling edge passes at once so the two sides of a pair never overlap.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= `ECP_DLY_ZERO;
      out_reg <= 1'b0;
    end else if (!level_i) begin
      count_reg <= `ECP_DLY_ZERO;
      out_reg <= 1'b0;
    end else if (!out_reg) begin
      if (count_reg == delay_i) begin
        out_reg <= 1'b1;
      end else if (tick_i) begin
        count_reg <= count_reg + `ECP_DLY_ONE;
      end
    end
  end

  assign level_o = out_reg;
endmodule // ecp_deadband

// File: ecp_pkg.sv
// Types shared by the enhanced CCP/PWM unit.
package ecp_pkg;
  typedef enum logic [1:0] {
    ecp_f_off,
    ecp_f_capture,
    ecp_f_compare,
    ecp_f_pwm
  } ecp_func_t;
  typedef logic [3:0] ecp_pins_t;
endpackage

// File: ecp_regs.svh
// Register offsets, field positions, codes and reset values of the enhanced CCP/PWM unit.
`ifndef ECP_REGS_SVH
`define ECP_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ECP_ADDR_UMC 5'h00
`define ECP_ADDR_DHB 5'h04
`define ECP_ADDR_TBS 5'h08
`define ECP_ADDR_ASC 5'h0C
`define ECP_ADDR_EPC 5'h10
`define ECP_ADDR_CAP 5'h14
`define ECP_ADDR_CMP 5'h18
`define ECP_ADDR_FLG 5'h1C

// ****************************************
// Field positions
// ****************************************
`define ECP_UMC_MODE 3:0
`define ECP_UMC_DUTYLO 5:4
`define ECP_UMC_BRIDGE 7:6
`define ECP_MODE_CLASS 3:2
`define ECP_TBS_ONE 1:0
`define ECP_ASC_STATUS 7
`define ECP_ASC_SRC 6:4
`define ECP_ASC_PAIR1 3:2
`define ECP_ASC_PAIR2 1:0
`define ECP_EPC_RESTART 7
`define ECP_EPC_DELAY 6:0
`define ECP_PSS_TRI 1
`define ECP_PSS_LVL 0
`define ECP_POL_AC 1
`define ECP_POL_BD 0
`define ECP_SRC_C1 0
`define ECP_SRC_C2 1
`define ECP_SRC_FLT 2
`define ECP_FLG_MATCH 0
`define ECP_BE_LO 0
`define ECP_BE_HI 1

// ****************************************
// Mode, bridge and timebase codes
// ****************************************
`define ECP_M_OFF 4'h0
`define ECP_M_TOGGLE 4'h2
`define ECP_M_CAP_FALL 4'h4
`define ECP_M_CAP_RISE 4'h5
`define ECP_M_CAP_4 4'h6
`define ECP_M_CAP_16 4'h7
`define ECP_M_CMP_SET 4'h8
`define ECP_M_CMP_CLR 4'h9
`define ECP_M_CMP_SOFT 4'hA
`define ECP_M_CMP_SPEC 4'hB
`define ECP_CLASS_CAP 2'h1
`define ECP_CLASS_CMP 2'h2
`define ECP_CLASS_PWM 2'h3
`define ECP_BR_SINGLE 2'h0
`define ECP_BR_FWD 2'h1
`define ECP_BR_HALF 2'h2
`define ECP_BR_REV 2'h3
`define ECP_TB_ONE 2'h0
`define ECP_TB_TWO 2'h1
`define ECP_TB_THREE 2'h2

// ****************************************
// Counts and reset values
// ****************************************
`define ECP_PRE4_LAST 4'h3
`define ECP_PRE16_LAST 4'hF
`define ECP_PRE_ZERO 4'h0
`define ECP_PRE_ONE 4'h1
`define ECP_QDIV_LAST 2'h3
`define ECP_QDIV_ZERO 2'h0
`define ECP_QDIV_ONE 2'h1
`define ECP_DLY_ZERO 7'h00
`define ECP_DLY_ONE 7'h01
`define ECP_RST8 8'h00
`define ECP_RST7 7'h00
`define ECP_RST10 10'h000
`define ECP_RST16 16'h0000
`define ECP_RST32 32'h00000000
`define ECP_PINS_OFF 4'hF
`define ECP_PINS_LOW 4'h0

`endif

// File: ecp_top.sv
// Enhanced capture/compare/PWM unit with auto-shutdown and an Avalon-MM register slave.
`timescale 1ns/100ps
`include "ecp_regs.svh"
module ecp_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Timers
  input wire logic [15:0] timer_value_i,
  input wire logic [9:0] tb0_count_i,
  input wire logic tb0_reload_i,
  input wire logic [9:0] tb1_count_i,
  input wire logic tb1_reload_i,
  input wire logic [9:0] tb2_count_i,
  input wire logic tb2_reload_i,
  // Capture input, shutdown sources and ADC enable
  input wire logic output_a_i,
  input wire logic cmp1_i,
  input wire logic cmp2_i,
  input wire logic fault_input_n_i,
  input wire logic adc_enabled_i,
  // Output pins
  output logic output_a_o,
  output logic output_a_oe_n_o,
  output logic output_b_o,
  output logic output_b_oe_n_o,
  output logic output_c_o,
  output logic output_c_oe_n_o,
  output logic output_d_o,
  output logic output_d_oe_n_o,
  // Events
  output logic match_flag_o,
  output logic timer_reset_o,
  output logic adc_start_o
);
  // ****************************************
  // Declarations
  // ****************************************
  logic waitrequest_reg;
  logic [31:0] readdata_reg;
  logic [31:0] rd_data;
  logic wr_go;
  logic wr_lo;
  logic [7:0] umc_reg;
  logic [7:0] dhb_reg;
  logic [7:0] tbs_reg;
  logic [6:0] asc_reg;
  logic [7:0] epc_reg;
  logic [15:0] cap_reg;
  logic [15:0] cmp_reg;
  logic shutdown_status_reg;
  logic match_flag_reg;
  logic [3:0] mode;
  logic [3:0] mode_prev_reg;
  logic mode_new;
  ecp_pkg::ecp_func_t func;
  logic pin_prev_reg;
  logic pin_rise;
  logic pin_fall;
  logic [3:0] pre_reg;
  logic cap_evt;
  logic eq_prev_reg;
  logic match_evt;
  logic cmp_flag_evt;
  logic spec_evt;
  logic cmp_out_reg;
  logic [2:0] src_vec;
  logic sd_src;
  logic [9:0] duty_latch_reg;
  logic [9:0] tb_count;
  logic tb_reload;
  logic tb_valid;
  logic pwm_level;
  logic [1:0] qdiv_reg;
  logic qtick;
  ecp_pkg::ecp_pins_t act;
  ecp_pkg::ecp_pins_t drv;
  ecp_pkg::ecp_pins_t dly;
  ecp_pkg::ecp_pins_t pin_next;
  ecp_pkg::ecp_pins_t oe_n_next;
  ecp_pkg::ecp_pins_t pin_reg;
  ecp_pkg::ecp_pins_t oe_n_reg;
  logic timer_reset_reg;
  logic adc_start_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  // Every access takes two cycles; the fixed answer keeps the slave free of stall paths.
  assign wr_go = write_i && !waitrequest_reg;
  assign wr_lo = wr_go && byteenable_i[`ECP_BE_LO];

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      waitrequest_reg <= 1'b1;
      readdata_reg <= `ECP_RST32;
    end else if ((read_i || write_i) && waitrequest_reg) begin
      waitrequest_reg <= 1'b0;
      readdata_reg <= rd_data;
    end else begin
      waitrequest_reg <= 1'b1;
    end
  end

  always_comb begin
    rd_data = `ECP_RST32;
    case (address_i)
      `ECP_ADDR_UMC: rd_data[7:0] = umc_reg;
      `ECP_ADDR_DHB: rd_data[7:0] = dhb_reg;
      `ECP_ADDR_TBS: rd_data[7:0] = tbs_reg;
      `ECP_ADDR_ASC: rd_data[7:0] = {shutdown_status_reg, asc_reg};
      `ECP_ADDR_EPC: rd_data[7:0] = epc_reg;
      `ECP_ADDR_CAP: rd_data[15:0] = cap_reg;
      `ECP_ADDR_CMP: rd_data[15:0] = cmp_reg;
      `ECP_ADDR_FLG: rd_data[`ECP_FLG_MATCH] = match_flag_reg;
      default: rd_data = `ECP_RST32;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      umc_reg <= `ECP_RST8;
      dhb_reg <= `ECP_RST8;
      tbs_reg <= `ECP_RST8;
      asc_reg <= `ECP_RST7;
      epc_reg <= `ECP_RST8;
    end else if (wr_lo) begin
      case (address_i)
        `ECP_ADDR_UMC: umc_reg <= writedata_i[7:0];
        `ECP_ADDR_DHB: dhb_reg <= writedata_i[7:0];
        `ECP_ADDR_TBS: tbs_reg <= writedata_i[7:0];
        `ECP_ADDR_ASC: asc_reg <= writedata_i[6:0];
        `ECP_ADDR_EPC: epc_reg <= writedata_i[7:0];
        default: umc_reg <= umc_reg;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_reg <= `ECP_RST16;
    end else if (wr_go && address_i == `ECP_ADDR_CMP) begin
      if (byteenable_i[`ECP_BE_LO]) cmp_reg[7:0] <= writedata_i[7:0];
      if (byteenable_i[`ECP_BE_HI]) cmp_reg[15:8] <= writedata_i[15:8];
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  assign mode = umc_reg[`ECP_UMC_MODE];
  assign mode_new = mode != mode_prev_reg;

  always_comb begin
    case (mode[`ECP_MODE_CLASS])
      `ECP_CLASS_CAP: func = ecp_pkg::ecp_f_capture;
      `ECP_CLASS_CMP: func = ecp_pkg::ecp_f_compare;
      `ECP_CLASS_PWM: func = ecp_pkg::ecp_f_pwm;
      default: func = (mode == `ECP_M_TOGGLE) ? ecp_pkg::ecp_f_compare
                                              : ecp_pkg::ecp_f_off;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mode_prev_reg <= `ECP_M_OFF;
    end else begin
      mode_prev_reg <= mode;
    end
  end

  // ****************************************
  // Capture
  // ****************************************
  assign pin_rise = output_a_i && !pin_prev_reg;
  assign pin_fall = !output_a_i && pin_prev_reg;

  always_comb begin
    case (mode)
      `ECP_M_CAP_FALL: cap_evt = pin_fall;
      `ECP_M_CAP_RISE: cap_evt = pin_rise;
      `ECP_M_CAP_4: cap_evt = pin_rise && pre_reg == `ECP_PRE4_LAST;
      `ECP_M_CAP_16: cap_evt = pin_rise && pre_reg == `ECP_PRE16_LAST;
      default: cap_evt = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_prev_reg <= 1'b0;
      pre_reg <= `ECP_PRE_ZERO;
      cap_reg <= `ECP_RST16;
    end else begin
      pin_prev_reg <= output_a_i;
      if (mode == `ECP_M_OFF || mode_new) begin
        pre_reg <= `ECP_PRE_ZERO;
      end else if (pin_rise && (mode == `ECP_M_CAP_4 || mode == `ECP_M_CAP_16)) begin
        pre_reg <= cap_evt ? `ECP_PRE_ZERO : pre_reg + `ECP_PRE_ONE;
      end
      if (cap_evt) cap_reg <= timer_value_i;
    end
  end

  // ****************************************
  // Compare
  // ****************************************
  // Only the first cycle of equality counts, so a stalled timer gives one event.
  assign match_evt = func == ecp_pkg::ecp_f_compare && timer_value_i == cmp_reg && !eq_prev_reg;
  assign cmp_flag_evt = match_evt && mode != `ECP_M_TOGGLE;
  assign spec_evt = match_evt && mode == `ECP_M_CMP_SPEC;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      eq_prev_reg <= 1'b0;
      cmp_out_reg <= 1'b0;
    end else begin
      eq_prev_reg <= timer_value_i == cmp_reg;
      if (mode == `ECP_M_OFF) begin
        cmp_out_reg <= 1'b0;
      end else if (mode_new && mode == `ECP_M_CMP_SET) begin
        cmp_out_reg <= 1'b0;
      end else if (mode_new && mode == `ECP_M_CMP_CLR) begin
        cmp_out_reg <= 1'b1;
      end else if (match_evt) begin
        case (mode)
          `ECP_M_TOGGLE: cmp_out_reg <= !cmp_out_reg;
          `ECP_M_CMP_SET: cmp_out_reg <= 1'b1;
          `ECP_M_CMP_CLR: cmp_out_reg <= 1'b0;
          default: cmp_out_reg <= cmp_out_reg;
        endcase
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      timer_reset_reg <= 1'b0;
      adc_start_reg <= 1'b0;
    end else begin
      timer_reset_reg <= spec_evt;
      adc_start_reg <= spec_evt && adc_enabled_i;
    end
  end

  // Set wins over a software clear in the same cycle.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      match_flag_reg <= 1'b0;
    end else if (cap_evt || cmp_flag_evt) begin
      match_flag_reg <= 1'b1;
    end else if (wr_lo && address_i == `ECP_ADDR_FLG && writedata_i[`ECP_FLG_MATCH]) begin
      match_flag_reg <= 1'b0;
    end
  end

  // ****************************************
  // Auto-shutdown
  // ****************************************
  assign src_vec[`ECP_SRC_C1] = cmp1_i;
  assign src_vec[`ECP_SRC_C2] = cmp2_i;
  assign src_vec[`ECP_SRC_FLT] = !fault_input_n_i;
  assign sd_src = |(asc_reg[`ECP_ASC_SRC] & src_vec);

  // Software may not clear the status while the source is still present.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      shutdown_status_reg <= 1'b0;
    end else if (sd_src) begin
      shutdown_status_reg <= 1'b1;
    end else if (wr_lo && address_i == `ECP_ADDR_ASC) begin
      shutdown_status_reg <= writedata_i[`ECP_ASC_STATUS];
    end else if (epc_reg[`ECP_EPC_RESTART]) begin
      shutdown_status_reg <= 1'b0;
    end
  end

  // ****************************************
  // PWM timebase and duty
  // ****************************************
  always_comb begin
    tb_count = tb0_count_i;
    tb_reload = tb0_reload_i;
    tb_valid = 1'b1;
    case (tbs_reg[`ECP_TBS_ONE])
      `ECP_TB_ONE: tb_count = tb0_count_i;
      `ECP_TB_TWO: begin
        tb_count = tb1_count_i;
        tb_reload = tb1_reload_i;
      end
      `ECP_TB_THREE: begin
        tb_count = tb2_count_i;
        tb_reload = tb2_reload_i;
      end
      default: begin
        tb_reload = 1'b0;
        tb_valid = 1'b0;
      end
    endcase
  end

  // Duty is taken at the period start so a write never gives a torn pulse.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      duty_latch_reg <= `ECP_RST10;
    end else if (func != ecp_pkg::ecp_f_pwm) begin
      duty_latch_reg <= `ECP_RST10;
    end else if (tb_reload) begin
      duty_latch_reg <= {dhb_reg, umc_reg[`ECP_UMC_DUTYLO]};
    end
  end

  assign pwm_level = tb_valid && tb_count < duty_latch_reg;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      qdiv_reg <= `ECP_QDIV_ZERO;
    end else begin
      qdiv_reg <= qdiv_reg + `ECP_QDIV_ONE;
    end
  end

  assign qtick = qdiv_reg == `ECP_QDIV_LAST;

  // ****************************************
  // Output steering and dead-band
  // ****************************************
  always_comb begin
    act = `ECP_PINS_LOW;
    drv = `ECP_PINS_LOW;
    if (func == ecp_pkg::ecp_f_pwm) begin
      case (umc_reg[`ECP_UMC_BRIDGE])
        `ECP_BR_SINGLE: begin
          act = {3'h0, pwm_level};
          drv = 4'h1;
        end
        `ECP_BR_HALF: begin
          act = {2'h0, !pwm_level, pwm_level};
          drv = 4'h3;
        end
        `ECP_BR_FWD: begin
          act = {pwm_level, 3'h1};
          drv = `ECP_PINS_OFF;
        end
        default: begin
          act = {1'b0, 1'b1, pwm_level, 1'b0};
          drv = `ECP_PINS_OFF;
        end
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_db
      ecp_deadband u_db (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .tick_i(qtick),
        .delay_i(epc_reg[`ECP_EPC_DELAY]),
        .level_i(act[gi]),
        .level_o(dly[gi])
      );
    end
  endgenerate

  always_comb begin
    pin_next = `ECP_PINS_LOW;
    oe_n_next = `ECP_PINS_OFF;
    if (func == ecp_pkg::ecp_f_compare) begin
      pin_next[0] = cmp_out_reg;
      oe_n_next[0] = mode == `ECP_M_CMP_SOFT || mode == `ECP_M_CMP_SPEC;
    end else if (func == ecp_pkg::ecp_f_pwm) begin
      for (int i = 0; i < 4; i++) begin
        if (drv[i] && shutdown_status_reg && (i == 0 || i == 2)) begin
          pin_next[i] = asc_reg[`ECP_ASC_PAIR1] == 2'h1;
          oe_n_next[i] = asc_reg[2 + `ECP_PSS_TRI];
        end else if (drv[i] && shutdown_status_reg) begin
          pin_next[i] = asc_reg[`ECP_ASC_PAIR2] == 2'h1;
          oe_n_next[i] = asc_reg[`ECP_PSS_TRI];
        end else if (drv[i]) begin
          pin_next[i] = dly[i] ^ mode[(i == 0 || i == 2) ? `ECP_POL_AC : `ECP_POL_BD];
          oe_n_next[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin_reg <= `ECP_PINS_LOW;
      oe_n_reg <= `ECP_PINS_OFF;
    end else begin
      pin_reg <= pin_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign readdata_o = readdata_reg;
  assign waitrequest_o = waitrequest_reg;
  assign output_a_o = pin_reg[0];
  assign output_a_oe_n_o = oe_n_reg[0];
  assign output_b_o = pin_reg[1];
  assign output_b_oe_n_o = oe_n_reg[1];
  assign output_c_o = pin_reg[2];
  assign output_c_oe_n_o = oe_n_reg[2];
  assign output_d_o = pin_reg[3];
  assign output_d_oe_n_o = oe_n_reg[3];
  assign match_flag_o = match_flag_reg;
  assign timer_reset_o = timer_reset_reg;
  assign adc_start_o = adc_start_reg;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_toggle_match;
    mode == `ECP_M_TOGGLE && !mode_new && match_evt;
  endsequence

  sequence s_spec_match;
    mode == `ECP_M_CMP_SPEC && match_evt;
  endsequence

  off_quiet_a: assert property (
    mode == `ECP_M_OFF [*2] |=> oe_n_reg == `ECP_PINS_OFF && !cmp_out_reg)
    else $error("Unit drives pins while off.");
  capture_load_a: assert property (
    cap_evt |=> cap_reg == $past(timer_value_i) && match_flag_reg)
    else $error("Capture did not load timer value.");
  toggle_match_a: assert property (
    s_toggle_match |=> cmp_out_reg != $past(cmp_out_reg))
    else $error("Compare toggle missed.");
  set_high_a: assert property (
    mode == `ECP_M_CMP_SET && !mode_new && match_evt |=> cmp_out_reg && match_flag_reg)
    else $error("Match did not set output high.");
  clear_low_a: assert property (
    mode == `ECP_M_CMP_CLR && !mode_new && match_evt |=> !cmp_out_reg && match_flag_reg)
    else $error("Match did not drive output low.");
  special_event_a: assert property (
    s_spec_match ##0 adc_enabled_i |=> timer_reset_o && adc_start_o)
    else $error("Special event trigger missing.");
  shutdown_set_a: assert property (
    sd_src |=> shutdown_status_reg ##1 (!$past(drv[0]) || (oe_n_reg[0] == $past(asc_reg[3])
      && pin_reg[0] == ($past(asc_reg[`ECP_ASC_PAIR1]) == 2'h1))))
    else $error("Shutdown source did not set status.");
  auto_restart_a: assert property (
    shutdown_status_reg && !sd_src && epc_reg[`ECP_EPC_RESTART] && !wr_go |=> !shutdown_status_reg)
    else $error("Auto-restart did not clear status.");
  port_pins_a: assert property (
    func == ecp_pkg::ecp_f_compare || func == ecp_pkg::ecp_f_capture |=> oe_n_reg[3:1] == 3'h7)
    else $error("Port pins driven outside PWM.");
  bus_answer_a: assert property (
    (read_i || write_i) && waitrequest_reg |=> !waitrequest_reg ##1 waitrequest_reg)
    else $error("Bus answer not in one cycle.");
endmodule // ecp_top

// File: testbench.sv
// Self-checking bench of the enhanced capture/compare/PWM unit.
`timescale 1ns/100ps
module testbench;
  logic clock_i = 1'h0;
  logic rst_i = 1'h1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic adc_en = 1'h1;
  logic ext_a = 1'h0;
  logic e;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [31:0] pon = 32'h900C301E;
  logic [31:0] poff = 32'hB03CB00E;
  logic [15:0] tv = 16'h0000;
  logic [9:0] cnt = 10'h000;
  logic [2:0] trip = 3'h0;
  logic [3:0] pin;
  logic [3:0] oe_n;
  logic [3:0] wire_l;
  logic wreq, flag, trst, adst, fault_n, c1, c2;
  int miscompares = 0;
  int n_tests = 0;
  int n_ev = 0;
  int i, j;
  ecp_top dut (.clock_i(clock_i), .rst_i(rst_i), .address_i(adr), .read_i(rd), .write_i(wr),
    .writedata_i(wd), .byteenable_i(4'hF), .readdata_o(rdata), .waitrequest_o(wreq),
    .timer_value_i(tv), .tb0_count_i(cnt), .tb0_reload_i(cnt == 10'h000),
    .tb1_count_i(cnt), .tb1_reload_i(cnt == 10'h000), .tb2_count_i(cnt),
    .tb2_reload_i(cnt == 10'h000), .output_a_i(wire_l[0]), .cmp1_i(c1), .cmp2_i(c2),
    .fault_input_n_i(fault_n), .adc_enabled_i(adc_en), .output_a_o(pin[0]),
    .output_a_oe_n_o(oe_n[0]), .output_b_o(pin[1]), .output_b_oe_n_o(oe_n[1]),
    .output_c_o(pin[2]), .output_c_oe_n_o(oe_n[2]), .output_d_o(pin[3]),
    .output_d_oe_n_o(oe_n[3]), .match_flag_o(flag), .timer_reset_o(trst), .adc_start_o(adst));
  ecp_bridge_model bridge (.pin_i(pin), .oe_n_i(oe_n), .trip_i(trip), .ext_a_i(ext_a),
    .wire_o(wire_l), .fault_n_o(fault_n), .cmp1_o(c1), .cmp2_o(c2));
  initial begin
    forever #2.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cnt <= cnt + 10'h001;
    n_ev <= n_ev + trst + adst;
  end
  // ********
  // Bus access, compare and verdict
  // ********
  task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wd <= d;
    do begin
      @(posedge clock_i);
    end while (wreq !== 1'h0);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clock_i);
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic pins_at(input logic [9:0] c, input string s, input logic [7:0] x);
    while (cnt !== c) @(posedge clock_i);
    chk(s, x, {wire_l, oe_n});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    results();
  end
  // ********
  // Tests
  // ********
  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'h0;
    bus(5'h0C, 1'h0, 32'h0); chk("shutdown reg", 32'h0, q);
    bus(5'h14, 1'h1, 32'hFFFF); bus(5'h14, 1'h0, 32'h0); chk("capture ro", 32'h0, q);
    bus(5'h02, 1'h1, 32'hFF); bus(5'h02, 1'h0, 32'h0); chk("unmapped", 32'h0, q);
    bus(5'h04, 1'h1, 32'h1A5); bus(5'h04, 1'h0, 32'h0); chk("duty high", 32'hA5, q);
    bus(5'h00, 1'h1, 32'h1); chk("reserved oe", 32'hF, oe_n);
    $display("register test done");
    bus(5'h18, 1'h1, 32'h10);
    for (j = 0; j < 4; j++) begin
      bus(5'h1C, 1'h1, 32'h1);
      bus(5'h00, 1'h1, {28'h0, 4'h8 + j[3:0]});
      repeat (3) @(posedge clock_i);
      if (j < 2) chk("compare init", j, wire_l[0]);
      i = n_ev;
      tv <= 16'h0010;
      repeat (4) @(posedge clock_i);
      tv <= 16'h0000;
      chk("compare pins", {j == 0, 3'h7, j > 1}, {wire_l[0], oe_n});
      bus(5'h1C, 1'h0, 32'h0); chk("match flag", 32'h1, q);
      chk("flag pin", 32'h1, flag);
      chk("special events", (j == 3) ? 32'h2 : 32'h0, n_ev - i);
    end
    adc_en <= 1'h0;
    i = n_ev;
    tv <= 16'h0010;
    repeat (4) @(posedge clock_i);
    tv <= 16'h0000;
    adc_en <= 1'h1;
    chk("gated events", 32'h1, n_ev - i);
    bus(5'h1C, 1'h1, 32'h1);
    bus(5'h00, 1'h1, 32'h2);
    for (j = 0; j < 2; j++) begin
      tv <= 16'h0010;
      repeat (4) @(posedge clock_i);
      chk("toggle pin", {j == 0, 1'h0}, {wire_l[0], oe_n[0]});
      tv <= 16'h0000;
      @(posedge clock_i);
    end
    chk("toggle flag", 32'h0, flag);
    $display("compare test done");
    for (j = 0; j < 2; j++) begin
      bus(5'h00, 1'h1, {28'h0, 4'h5 - j[3:0]});
      tv <= {12'h123, j[3:0]};
      @(posedge clock_i);
      ext_a <= ~ext_a;
      repeat (4) @(posedge clock_i);
      bus(5'h14, 1'h0, 32'h0); chk("capture", {12'h123, j[3:0]}, q);
    end
    for (i = 0; i < 2; i++) begin
      bus(5'h00, 1'h1, {28'h0, 4'h6 + i[3:0]});
      for (j = 1; j <= (i ? 32 : 28); j++) begin
        tv <= {i[7:0], j[7:0]};
        ext_a <= j[0];
        @(posedge clock_i);
      end
      bus(5'h14, 1'h0, 32'h0); chk("capture nth", i ? 32'h011F : 32'h0017, q);
    end
    $display("capture test done");
    bus(5'h10, 1'h1, 32'h0);
    bus(5'h00, 1'h1, 32'h8C);
    repeat (2) @(posedge clock_i);
    chk("half bridge oe", 32'hC, oe_n);
    for (i = 0; i < 8; i++) for (j = 0; j < 3; j++) begin
      bus(5'h0C, 1'h1, {24'h0, 1'h0, i[2:0], j[1:0], 2'h2 - j[1:0]});
      trip <= 3'h1 << j;
      repeat (4) @(posedge clock_i);
      e = (j == 0 && i[2]) || (j == 1 && i[0]) || (j == 2 && i[1]);
      bus(5'h0C, 1'h0, 32'h0);
      chk("status", {e, i[2:0], j[1:0], 2'h2 - j[1:0]}, q);
      if (e) chk("shut pins", {j == 1, j == 1, j == 0, j == 2}, {wire_l[1:0], oe_n[1:0]});
      trip <= 3'h0;
      repeat (4) @(posedge clock_i);
      bus(5'h0C, 1'h0, 32'h0); chk("held status", e, q[7]);
    end
    $display("shutdown test done");
    bus(5'h10, 1'h1, 32'h80);
    bus(5'h0C, 1'h1, 32'h40);
    trip <= 3'h1;
    repeat (4) @(posedge clock_i);
    bus(5'h0C, 1'h0, 32'h0); chk("fault status", 32'hC0, q);
    trip <= 3'h0;
    repeat (4) @(posedge clock_i);
    bus(5'h0C, 1'h0, 32'h0); chk("restart status", 32'h40, q);
    chk("restart oe", 32'hC, oe_n);
    $display("restart test done");
    for (j = 0; j < 4; j++) begin
      bus(5'h00, 1'h1, {24'h0, j[1:0], 4'h3, j[1:0]});
      repeat (4) @(posedge clock_i);
      pins_at(10'h064, "pwm active", pon[8 * j +: 8]);
      pins_at(10'h320, "pwm idle", poff[8 * j +: 8]);
    end
    bus(5'h00, 1'h1, 32'hC);
    bus(5'h10, 1'h1, 32'hFF);
    repeat (4) @(posedge clock_i);
    pins_at(10'h320, "delay idle", 8'h0E);
    pins_at(10'h12C, "delay wait", 8'h0E);
    pins_at(10'h258, "delay active", 8'h1E);
    bus(5'h08, 1'h1, 32'h3);
    repeat (4) @(posedge clock_i);
    pins_at(10'h258, "no timebase", 8'h0E);
    $display("pwm test done");
    results();
  end
endmodule // testbench
